// File: pkg/amp_diag_defs.svh
// Purpose: constants for the diagnostic status readback block
// Assumes: byte numbering starts at one for the first byte sent
// Notes: bit positions are within each 8-bit status byte
// Function
// - read address returns diagnostic bytes to host
// - read clears all flags except load class, max temperature and offset
// - offset bit is set after a read
// - clear only after all five bytes read
// - byte one bit 7 is temperature prewarning
// - bit 6 is speaker fault per channel
// - bytes one and two carry channels two, four
// - ac mode: bit 4 is ac load detected
// - dc mode: bits 5..4 hold load class code
// - bit 3 flags shorted load
// - bit 2 flags output offset
// - bit 1 flags short to supply
// - bit 0 flags short to ground
// - byte two bit 7 is power-on reset status
// - byte three bit 7 is max temperature protection
// - instruction byte four bit 4 selects ac/dc
// - byte three carries channel one fields
`ifndef AMP_DIAG_DEFS_SVH
`define AMP_DIAG_DEFS_SVH

// ==========================================================
// field positions
`define BIT_TOP 7
`define BIT_SPK 6
`define BIT_LD_HI 5
`define BIT_LD_LO 4
`define BIT_SHORT 3
`define BIT_OFFS 2
`define BIT_SUP 1
`define BIT_GND 0
`define IB4_ACSEL 4
// ==========================================================
// transfer
`define NUM_BYTES 3'h5
`define DEV_ADDR_DEF 7'h6c
`define POR_RESET 1'b1

`endif

// File: pkg/amp_diag_pkg.sv
// Purpose: types for the diagnostic status readback block
// Assumes: nothing beyond the defs header
// Notes: link side state machine states
`default_nettype none
package amp_diag_pkg;
  typedef enum logic [2:0] {LIdle, LAddr, LAddrAck, LTx, LTxAck, LWait} link_state_t;
  typedef logic [7:0] byte_t;
endpackage : amp_diag_pkg
`default_nettype wire

// File: hdl/sync_pulse.sv
// Purpose: carry a one-cycle event from the link domain to the system domain
// Assumes: events at least a few destination cycles apart
// Notes: toggle in, three flops, edge out
`default_nettype none
module sync_pulse (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic srcToggle,
  output logic dstPulse
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } st_t;
  st_t st_r;
  st_t st_nxt;

  // first flop feeds only the second
  always_comb begin
    st_nxt.s1 = srcToggle;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dstPulse = st_r.s2 ^ st_r.s3;
endmodule : sync_pulse
`default_nettype wire

// File: hdl/amp_diag_status_readback.sv
// Purpose: hold diagnostic flags and return them over the serial bus on read
// Assumes: scl is the bus clock, running only while the host drives frames
// Notes: a snapshot of the system-domain bytes is taken in the link domain at the address match and kept stable for the link
`include "amp_diag_defs.svh"
`default_nettype none
module amp_diag_status_readback
  import amp_diag_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sclClk,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic [6:0] devAddr,
  input wire logic acLoadSelect,
  input wire logic tempPrewarnEvt,
  input wire logic maxTempProt,
  input wire logic ampEnabled,
  input wire logic [3:0] spkFaultEvt,
  input wire logic [3:0] shortLoadEvt,
  input wire logic [3:0] offsetEvt,
  input wire logic [3:0] shortSupEvt,
  input wire logic [3:0] shortGndEvt,
  input wire logic [3:0] acLoadDet,
  input wire logic [7:0] dcLoadCode,
  output logic [7:0] diag_status_byte_one,
  output logic [7:0] diag_status_byte_two,
  output logic [7:0] diag_status_byte_three,
  output logic readDone
);
  // ==========================================================
  // system domain state
  // channel index: 0 = ch1, 1 = ch2, 2 = ch3, 3 = ch4
  typedef struct packed {
    logic [1:0] acSelSync;
    logic [1:0] maxTSync;
    logic [1:0] enSync;
    logic [1:0] tpwSync;
    logic [3:0] spkS1;
    logic [3:0] spkS2;
    logic [3:0] shlS1;
    logic [3:0] shlS2;
    logic [3:0] offS1;
    logic [3:0] offS2;
    logic [3:0] supS1;
    logic [3:0] supS2;
    logic [3:0] gndS1;
    logic [3:0] gndS2;
    logic [3:0] acS1;
    logic [3:0] acS2;
    logic [7:0] dcS1;
    logic [7:0] dcS2;
    logic tempPw;
    logic por;
    logic maxT;
    logic [3:0] spk;
    logic [3:0] shl;
    logic [3:0] off;
    logic [3:0] sup;
    logic [3:0] gnd;
    logic [3:0] acl;
    logic [7:0] dcl;
    byte_t b1;
    byte_t b2;
    byte_t b3;
    logic done;
  } sys_t;
  sys_t sys_r;
  sys_t sys_nxt;

  // link domain state
  typedef struct packed {
    link_state_t st;
    logic [2:0] bitCnt;
    logic [7:0] sh;
    logic [2:0] byteCnt;
    logic drive;
    logic doneTgl;
    logic [7:0] cap1;
    logic [7:0] cap2;
    logic [7:0] cap3;
  } lnk_t;
  lnk_t lnk_r;
  lnk_t lnk_nxt;

  logic fullRead;
  logic sdaS1;
  logic sdaS2;
  logic sdaPrev;
  logic startSeen;
  logic stopSeen;

  // ==========================================================
  // per-channel byte builder, shared by all three bytes
  function automatic byte_t chanByte(input logic top, input logic spk, input logic acSel,
                                     input logic ac, input logic [1:0] dc, input logic shl,
                                     input logic off, input logic sup, input logic gnd);
    byte_t b;
    b = 8'h00;
    b[`BIT_TOP] = top;
    b[`BIT_SPK] = spk;
    if (acSel) begin
      b[`BIT_LD_HI] = 1'b0; // don't-care in ac mode
      b[`BIT_LD_LO] = ac;
    end else begin
      b[`BIT_LD_HI:`BIT_LD_LO] = dc;
    end
    b[`BIT_SHORT] = shl;
    b[`BIT_OFFS] = off;
    b[`BIT_SUP] = sup;
    b[`BIT_GND] = gnd;
    return b;
  endfunction : chanByte

  // read completion crosses from the link as a toggle
  sync_pulse u_done (
    .clk(clk),
    .sys_rst(sys_rst),
    .srcToggle(lnk_r.doneTgl),
    .dstPulse(fullRead)
  );

  // ==========================================================
  // sticky flags: synchronise, set on events, clear after a full read
  always_comb begin
    sys_nxt = sys_r;
    sys_nxt.acSelSync = {sys_r.acSelSync[0], acLoadSelect};
    sys_nxt.maxTSync = {sys_r.maxTSync[0], maxTempProt};
    sys_nxt.enSync = {sys_r.enSync[0], ampEnabled};
    sys_nxt.tpwSync = {sys_r.tpwSync[0], tempPrewarnEvt};
    sys_nxt.spkS1 = spkFaultEvt;
    sys_nxt.spkS2 = sys_r.spkS1;
    sys_nxt.shlS1 = shortLoadEvt;
    sys_nxt.shlS2 = sys_r.shlS1;
    sys_nxt.offS1 = offsetEvt;
    sys_nxt.offS2 = sys_r.offS1;
    sys_nxt.supS1 = shortSupEvt;
    sys_nxt.supS2 = sys_r.supS1;
    sys_nxt.gndS1 = shortGndEvt;
    sys_nxt.gndS2 = sys_r.gndS1;
    sys_nxt.acS1 = acLoadDet;
    sys_nxt.acS2 = sys_r.acS1;
    sys_nxt.dcS1 = dcLoadCode;
    sys_nxt.dcS2 = sys_r.dcS1;
    // load class is live status and never cleared by a read
    sys_nxt.acl = sys_r.acS2;
    sys_nxt.dcl = sys_r.dcS2;
    sys_nxt.maxT = sys_r.maxTSync[1];
    sys_nxt.done = fullRead;
    if (fullRead) begin
      // only a complete five-byte read clears; offset goes to one
      sys_nxt.tempPw = 1'b0;
      sys_nxt.por = 1'b0;
      sys_nxt.spk = 4'h0;
      sys_nxt.shl = 4'h0;
      sys_nxt.off = 4'hf;
      sys_nxt.sup = 4'h0;
      sys_nxt.gnd = 4'h0;
    end
    // set wins over the clear in the same cycle
    sys_nxt.tempPw = sys_nxt.tempPw | sys_r.tpwSync[1];
    sys_nxt.spk = sys_nxt.spk | sys_r.spkS2;
    sys_nxt.shl = sys_nxt.shl | sys_r.shlS2;
    sys_nxt.off = sys_nxt.off | sys_r.offS2;
    sys_nxt.sup = sys_nxt.sup | sys_r.supS2;
    sys_nxt.gnd = sys_nxt.gnd | sys_r.gndS2;
    // power-on flag holds until the amplifier is enabled and a read clears it
    sys_nxt.por = sys_nxt.por | ~sys_r.enSync[1];
    sys_nxt.b1 = chanByte(sys_r.tempPw, sys_r.spk[1], sys_r.acSelSync[1], sys_r.acl[1],
                          sys_r.dcl[3:2], sys_r.shl[1], sys_r.off[1], sys_r.sup[1],
                          sys_r.gnd[1]);
    sys_nxt.b2 = chanByte(sys_r.por, sys_r.spk[3], sys_r.acSelSync[1], sys_r.acl[3],
                          sys_r.dcl[7:6], sys_r.shl[3], sys_r.off[3], sys_r.sup[3],
                          sys_r.gnd[3]);
    sys_nxt.b3 = chanByte(sys_r.maxT, sys_r.spk[0], sys_r.acSelSync[1], sys_r.acl[0],
                          sys_r.dcl[1:0], sys_r.shl[0], sys_r.off[0], sys_r.sup[0],
                          sys_r.gnd[0]);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sys_r <= '0;
      sys_r.por <= `POR_RESET;
    end else begin
      sys_r <= sys_nxt;
    end
  end

  assign diag_status_byte_one = sys_r.b1;
  assign diag_status_byte_two = sys_r.b2;
  assign diag_status_byte_three = sys_r.b3;
  assign readDone = sys_r.done;

  // ==========================================================
  // sda sampled by scl-domain flops; start and stop are not detected
  // sda passes three flops on scl rising edges; startSeen and stopSeen are tied low
  always_ff @(posedge sclClk or posedge sys_rst) begin
    if (sys_rst) begin
      sdaS1 <= 1'b1;
      sdaS2 <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sdaS1 <= sdaIn;
      sdaS2 <= sdaS1;
      sdaPrev <= sdaS2;
    end
  end

  // start and stop are level changes of sda during scl high; sampled on
  // the falling edge they show as sda value differing from the rising sample
  logic sdaFall;
  logic sdaRise;
  always_ff @(negedge sclClk or posedge sys_rst) begin
    if (sys_rst) begin
      sdaFall <= 1'b1;
    end else begin
      sdaFall <= sdaS1;
    end
  end
  always_ff @(posedge sclClk or posedge sys_rst) begin
    if (sys_rst) begin
      sdaRise <= 1'b1;
    end else begin
      sdaRise <= sdaIn;
    end
  end
  // limitation: no true start/stop; a frame opens on sda low at a bus clock rise in idle
  assign startSeen = 1'b0;
  assign stopSeen = 1'b0;

  // ==========================================================
  // link machine: address, then bytes out msb first, host acks each of the first four
  // snapshot bytes are stable while the link reads them (flags change slowly)
  always_comb begin
    lnk_nxt = lnk_r;
    unique case (lnk_r.st)
      LIdle: begin
        lnk_nxt.drive = 1'b0;
        // sda read at the edge itself so the ack lands in the slot the host samples
        if (!sdaIn) begin
          lnk_nxt.st = LAddr;
          lnk_nxt.bitCnt = 3'h0;
          lnk_nxt.sh = 8'h00;
          lnk_nxt.byteCnt = 3'h0;
        end
      end
      LAddr: begin
        lnk_nxt.sh = {lnk_r.sh[6:0], sdaIn};
        lnk_nxt.bitCnt = lnk_r.bitCnt + 3'h1;
        if (lnk_r.bitCnt == 3'h7) begin
          if (lnk_nxt.sh[7:1] == devAddr && lnk_nxt.sh[0]) begin
            lnk_nxt.st = LAddrAck;
            lnk_nxt.cap1 = sys_r.b1;
            lnk_nxt.cap2 = sys_r.b2;
            lnk_nxt.cap3 = sys_r.b3;
          end else begin
            lnk_nxt.st = LWait;
          end
        end
      end
      LAddrAck: begin
        lnk_nxt.st = LTx;
        lnk_nxt.sh = lnk_r.cap1;
        lnk_nxt.bitCnt = 3'h0;
      end
      LTx: begin
        lnk_nxt.bitCnt = lnk_r.bitCnt + 3'h1;
        if (lnk_r.bitCnt == 3'h7) begin
          lnk_nxt.st = LTxAck;
          lnk_nxt.byteCnt = lnk_r.byteCnt + 3'h1;
        end else begin
          lnk_nxt.sh = {lnk_r.sh[6:0], 1'b0};
        end
      end
      LTxAck: begin
        if (lnk_r.byteCnt == `NUM_BYTES) begin
          lnk_nxt.doneTgl = ~lnk_r.doneTgl;
          lnk_nxt.st = LWait;
        end else if (!sdaIn) begin
          lnk_nxt.st = LTx; // host ack, next byte in order
          lnk_nxt.bitCnt = 3'h0;
          unique case (lnk_r.byteCnt)
            3'h1: lnk_nxt.sh = lnk_r.cap2;
            3'h2: lnk_nxt.sh = lnk_r.cap3;
            default: lnk_nxt.sh = 8'h00; // bytes four and five belong elsewhere
          endcase
        end else begin
          lnk_nxt.st = LWait; // nack: short read, flags kept
        end
      end
      LWait: begin
        if (sdaIn) begin
          lnk_nxt.st = LIdle;
        end
      end
      default: lnk_nxt.st = LIdle;
    endcase
    lnk_nxt.drive = (lnk_nxt.st == LAddrAck) || (lnk_nxt.st == LTx);
  end

  always_ff @(posedge sclClk or posedge sys_rst) begin
    if (sys_rst) begin
      lnk_r <= '0;
    end else begin
      lnk_r <= lnk_nxt;
    end
  end

  // open drain: enable low while driving, drive low for ack or zero bits
  assign sdaOut = (lnk_r.st == LTx) ? lnk_r.sh[7] : 1'b0;
  assign sdaOe = ~(lnk_r.drive && !((lnk_r.st == LTx) && lnk_r.sh[7]));
endmodule : amp_diag_status_readback
`default_nettype wire

// File: sim/amp_diag_status_readback_asserts.sv
// Purpose: port-level checks of the diagnostic readback block
// Assumes: fault inputs stay quiet while a full read completes
// Notes: bound into every instance of the block at the foot
`default_nettype none
module amp_diag_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic acLoadSelect,
  input wire logic tempPrewarnEvt,
  input wire logic maxTempProt,
  input wire logic ampEnabled,
  input wire logic [3:0] spkFaultEvt,
  input wire logic [3:0] shortLoadEvt,
  input wire logic [3:0] shortSupEvt,
  input wire logic [3:0] shortGndEvt,
  input wire logic [3:0] acLoadDet,
  input wire logic [7:0] dcLoadCode,
  input wire logic [7:0] diag_status_byte_one,
  input wire logic [7:0] diag_status_byte_two,
  input wire logic [7:0] diag_status_byte_three,
  input wire logic readDone
);
  // ==========================================================
  // short aliases; quiet means no set can race the clear
  wire [7:0] b1 = diag_status_byte_one;
  wire [7:0] b2 = diag_status_byte_two;
  wire [7:0] b3 = diag_status_byte_three;
  wire quiet = !tempPrewarnEvt && ampEnabled &&
    ~|{spkFaultEvt, shortLoadEvt, shortSupEvt, shortGndEvt};
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_done_pulse; readDone |=> !readDone; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done pulse too long");
  property p_offset_set; (readDone && quiet) |-> ##[0:4] (b1[2] && b2[2] && b3[2]); endproperty
  a_offset_set: assert property (p_offset_set) else $error("offset not set");
  property p_clear;
    (readDone && quiet) |-> ##[0:4] ((b1 & 8'hcb) == 8'h00 && (b2 & 8'hcb) == 8'h00
      && (b3 & 8'h4b) == 8'h00);
  endproperty
  a_clear: assert property (p_clear) else $error("flags not cleared");
  property p_load_hold;
    ($stable(dcLoadCode) && $stable(acLoadDet) && $stable(acLoadSelect))[*6] |=>
      $stable(b1[5:4]) && $stable(b2[5:4]) && $stable(b3[5:4]);
  endproperty
  a_load_hold: assert property (p_load_hold) else $error("load bits moved");
  property p_dc_map;
    (!acLoadSelect && $stable(dcLoadCode))[*6] |-> b3[5:4] == dcLoadCode[1:0] &&
      b1[5:4] == dcLoadCode[3:2] && b2[5:4] == dcLoadCode[7:6];
  endproperty
  a_dc_map: assert property (p_dc_map) else $error("dc load code");
  property p_ac_map;
    (acLoadSelect && $stable(acLoadDet))[*6] |-> b3[5:4] == {1'b0, acLoadDet[0]} &&
      b1[5:4] == {1'b0, acLoadDet[1]} && b2[5:4] == {1'b0, acLoadDet[3]};
  endproperty
  a_ac_map: assert property (p_ac_map) else $error("ac load bit");
  property p_max_temp; maxTempProt[*6] |-> b3[7]; endproperty
  a_max_temp: assert property (p_max_temp) else $error("max temp bit");
  property p_prewarn; tempPrewarnEvt[*4] |-> ##[0:4] b1[7]; endproperty
  a_prewarn: assert property (p_prewarn) else $error("prewarning bit");
  property p_spk_map; spkFaultEvt[3][*4] |-> ##[0:4] b2[6]; endproperty
  a_spk_map: assert property (p_spk_map) else $error("speaker fault ch4");
  // main scenarios
  c_done: cover property (readDone);
  c_ac: cover property (acLoadSelect && b1[4]);
  c_dc_open: cover property (!acLoadSelect && b3[5:4] == 2'h2);
endmodule : amp_diag_checker
bind amp_diag_status_readback amp_diag_checker u_chk (.clk(clk), .sys_rst(sys_rst),
  .acLoadSelect(acLoadSelect), .tempPrewarnEvt(tempPrewarnEvt), .maxTempProt(maxTempProt),
  .ampEnabled(ampEnabled), .spkFaultEvt(spkFaultEvt), .shortLoadEvt(shortLoadEvt),
  .shortSupEvt(shortSupEvt), .shortGndEvt(shortGndEvt), .acLoadDet(acLoadDet),
  .dcLoadCode(dcLoadCode), .diag_status_byte_one(diag_status_byte_one),
  .diag_status_byte_two(diag_status_byte_two),
  .diag_status_byte_three(diag_status_byte_three), .readDone(readDone));
`default_nettype wire

// File: sim/amp_host_model.sv
// Purpose: serial bus host that reads the diagnostic bytes
// Assumes: bench resolves the data wire with a pull-up
// Notes: bus clock stands low outside frames, 48 ns period inside
`default_nettype none
module amp_host_model (
  output logic sclClk,
  output logic hostSda,
  input wire logic sdaWire
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // idle: clock still, data released
  initial begin
    sclClk = 1'b0;
    hostSda = 1'b1;
  end
  // one bus clock, wire sampled at the rising edge
  task automatic pulse(output logic s);
    #24 sclClk = 1'b1;
    s = sdaWire;
    #24 sclClk = 1'b0;
  endtask : pulse
  // read frame: nAck bytes acknowledged, then one refused to end it
  task automatic readFrame(input logic [6:0] addr, input int nAck, output logic ack,
                           output logic [7:0] q [5]);
    logic s;
    logic [7:0] a;
    q = '{default: 8'h00};
    a = {addr, 1'b1}; // read direction
    // opening clock with data low marks the frame for the device
    hostSda = 1'b0;
    pulse(s);
    for (int i = 7; i >= 0; i--) begin
      hostSda = a[i];
      pulse(s);
    end
    hostSda = 1'b1;
    pulse(ack);
    for (int b = 0; b <= nAck && ack == 1'b0; b++) begin
      for (int i = 7; i >= 0; i--) begin
        pulse(s);
        q[b][i] = s;
      end
      hostSda = (b < nAck) ? 1'b0 : 1'b1;
      pulse(s);
      hostSda = 1'b1;
    end
    // closing clock with data high returns the device to idle
    hostSda = 1'b1;
    pulse(s);
    #96;
  endtask : readFrame
endmodule : amp_host_model
`default_nettype wire

// File: sim/testbench.sv
// Purpose: self-checking bench for the diagnostic readback block
// Assumes: fault inputs quiet while a read is in progress
// Notes: random faults from a fixed seed, corners at the first passes
`include "amp_diag_defs.svh"
`default_nettype none
module testbench import amp_diag_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, sysRst, sclClk, hostSda, sdaOut, sdaOe, acSel, prew, maxT, ampEn, readDone, ack;
  logic [3:0] spk, shl, off, sup, gnd, acDet, eSpk, eShl, eOff, eSup, eGnd;
  logic [6:0] devAddr;
  logic [7:0] dc, b1, b2, b3, r, pm;
  logic ePrew, ePor;
  logic [31:0] ev;
  byte_t q [5];
  byte_t e [3];
  int nFail, nTests, nDone, d0, seed;
  wire sdaWire = hostSda & (sdaOe | sdaOut); // pull-up; device drives while enable low
  // ==========================================================
  // clock, completion counter, partner
  always #4 clk = ~clk;
  always @(posedge clk) if (readDone === 1'b1) nDone <= nDone + 1;
  amp_diag_status_readback u_dut (.clk(clk), .sys_rst(sysRst), .sclClk(sclClk),
    .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe), .devAddr(devAddr), .acLoadSelect(acSel),
    .tempPrewarnEvt(prew), .maxTempProt(maxT), .ampEnabled(ampEn), .spkFaultEvt(spk),
    .shortLoadEvt(shl), .offsetEvt(off), .shortSupEvt(sup), .shortGndEvt(gnd),
    .acLoadDet(acDet), .dcLoadCode(dc), .diag_status_byte_one(b1),
    .diag_status_byte_two(b2), .diag_status_byte_three(b3), .readDone(readDone));
  amp_host_model u_host (.sclClk(sclClk), .hostSda(hostSda), .sdaWire(sdaWire));
  // expected image of byte n from the shadow flags and live load inputs
  function automatic byte_t expB(input int n);
    int c;
    c = (n == 1) ? 1 : (n == 2) ? 3 : 0;
    return {(n == 1) ? ePrew : (n == 2) ? ePor : maxT, eSpk[c],
      acSel ? {1'b0, acDet[c]} : dc[2*c +: 2], eShl[c], eOff[c], eSup[c], eGnd[c]};
  endfunction : expB
  task automatic chk(input byte_t got, input byte_t exp, input byte_t m);
    nTests++;
    if ((got & m) !== (exp & m)) begin
      nFail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chkAll;
    chk(b1, expB(1), 8'hff);
    chk(b2, expB(2), pm);
    chk(b3, expB(3), 8'hff);
  endtask : chkAll
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", nTests, nFail);
    if (nFail == 0 && nTests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  // hang guard, well beyond six read frames
  initial begin
    #300000;
    nFail++;
    conclude;
  end
  // main sequence: reset, then six passes of faults and reads
  initial begin
    {clk, acSel, prew, maxT, ampEn, spk, shl, off, sup, gnd, acDet, dc} = '0;
    {eSpk, eShl, eOff, eSup, eGnd, ePrew, nFail, nTests, nDone} = '0;
    sysRst = 1'b1;
    seed = 32'h1c12;
    devAddr = `DEV_ADDR_DEF;
    repeat (20) @(posedge clk);
    sysRst <= 1'b0;
    repeat (10) @(posedge clk);
    ePor = 1'b1;
    pm = 8'hff;
    chkAll;
    $display("reset test done");
    ampEn <= 1'b1;
    pm = 8'h7f;
    for (int k = 0; k < 6; k++) begin
      ev = (k == 0) ? 32'h003f_ffff : $random(seed);
      r = (k == 1) ? 8'h24 : $random(seed);
      spk <= ev[3:0];
      shl <= ev[7:4];
      off <= ev[11:8];
      sup <= ev[15:12];
      gnd <= ev[19:16];
      prew <= ev[20];
      maxT <= ev[21];
      acSel <= ev[22] & (k != 1);
      acDet <= ev[27:24];
      dc <= r & ~((r & 8'haa) >> 1); // code 11 never offered
      repeat (4) @(posedge clk);
      {spk, shl, off, sup, gnd, prew} <= '0;
      {eSpk, eShl, eOff} = {eSpk | ev[3:0], eShl | ev[7:4], eOff | ev[11:8]};
      {eSup, eGnd, ePrew} = {eSup | ev[15:12], eGnd | ev[19:16], ePrew | ev[20]};
      repeat (12) @(posedge clk);
      chkAll;
      e = '{expB(1), expB(2), expB(3)};
      d0 = nDone;
      u_host.readFrame((k == 1) ? ~devAddr : devAddr, (k == 0) ? 1 : 4, ack, q);
      chk({7'h0, ack}, {7'h0, k == 1}, 8'h01);
      if (k != 1) for (int i = 0; i < ((k == 0) ? 2 : 5); i++)
        chk(q[i], (i < 3) ? e[i] : 8'h00, (i == 1) ? pm : 8'hff);
      repeat (20) @(posedge clk);
      if (k > 1) begin
        {eSpk, eShl, eSup, eGnd, ePrew, ePor} = '0;
        eOff = 4'hf;
        pm = 8'hff;
      end
      chk(nDone[7:0], d0[7:0] + ((k > 1) ? 8'h01 : 8'h00), 8'hff);
      chkAll;
      $display("pass %0d done", k);
    end
    conclude;
  end
endmodule : testbench
`default_nettype wire
